//--- verilog/fsp_pkg.sv
// constants, register map and types of the four-mode serial port
// assumes a 32-bit classic wishbone master and timer overflow pulses on sys_clk
package fsp_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
    localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] IDX_SERIAL_DATA    = 8'h99;
    localparam logic [7:0] IDX_RATE_SELECT    = 8'h9a;

    // reset values
    localparam logic [7:0] RST_POWER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_SERIAL_DATA    = 8'h00;
    localparam logic [1:0] RST_RATE_SELECT    = 2'h0;

    // power_control fields
    localparam int BIT_BAUD_DOUBLE = 7;

    // serial_control fields
    localparam int BIT_MODE_HIGH = 7;
    localparam int BIT_MODE_LOW  = 6;
    localparam int BIT_MP_ENABLE = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_TX_NINTH  = 3;
    localparam int BIT_RX_NINTH  = 2;
    localparam int BIT_TX_DONE   = 1;
    localparam int BIT_RX_DONE   = 0;

    // rate_select fields
    localparam int BIT_TX_SRC = 0;
    localparam int BIT_RX_SRC = 1;

    // timing: ratios to the oscillator and oversampling
    localparam int         MODE0_DIV    = 12;
    localparam logic [3:0] MODE0_LAST   = 4'(MODE0_DIV - 1);
    localparam logic [3:0] MODE0_RISE   = 4'(MODE0_DIV / 2);
    localparam int         OVERSAMPLE   = 16;
    localparam logic [3:0] SUB_LAST     = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] SUB_CENTRE   = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] FRAME_BITS8  = 4'ha;
    localparam logic [3:0] FRAME_BITS9  = 4'hb;

    typedef enum logic [1:0] {
        FSP_MODE_SHIFT   = 2'b00,
        FSP_MODE_ASYNC8  = 2'b01,
        FSP_MODE_FIXED9  = 2'b10,
        FSP_MODE_VAR9    = 2'b11
    } fsp_mode_t;

    typedef enum logic [1:0] {
        FSP_RX_IDLE  = 2'b00,
        FSP_RX_START = 2'b01,
        FSP_RX_DATA  = 2'b10,
        FSP_RX_STOP  = 2'b11
    } fsp_rx_state_t;

endpackage

//--- verilog/fsp_serial_port.sv
// four-mode serial port: wishbone register slave, transmitter, receiver
// assumes timer overflow pulses are one sys_clk wide and on the same clock
//
// What this block does
// RULE1: writing the data register loads transmit buffer and starts a frame
// RULE2: reading the data register address returns the separate receive buffer
// RULE3: transmit and receive run together; receiver holds one byte while assembling next
// RULE4: two mode bits select shift, 8-bit async, fixed 9-bit, variable 9-bit
// RULE5: receiving only while receive enable is set; clearing it stops reception
// RULE6: 9-bit modes transmit the software ninth bit as ninth data bit
// RULE7: received ninth bit stored; 8-bit mode without multiprocessor stores stop bit
// RULE8: transmit-done flag set at frame end; only software clears it
// RULE9: receive-done flag set at reception end; only software clears it
// RULE10: shift mode: data pin bidirectional, transmit pin clocks, 8 bits lsb first
// RULE11: shift mode reception starts when done flag clear and enable set
// RULE12: async modes start receiving on a start bit while enabled
// RULE13: 8-bit async frame is start, eight data lsb first, stop; no clock
// RULE14: 8-bit async reception: start syncs, data to buffer, stop to ninth field
// RULE15: fixed 9-bit mode sends eleven bits at oscillator over 32 or 64
// RULE16: variable 9-bit mode equals fixed mode but uses timer rate
// RULE17: multiprocessor enable set: ninth bit zero frames raise no done flag
// RULE18: a master sends address frames with ninth bit one, data with zero
// RULE19: matched receiver clears multiprocessor enable to accept data frames
// RULE20: timer 1 source: bit rate is overflow rate over 16 or 32
// RULE21: timer 2 source: bit rate is overflow rate over 32 always
// RULE22: separate select bits choose timer 2 for receive or transmit rate
// RULE23: async receiver oversamples sixteen times, finds start edge, samples centres
//
// Implementation choice: the Wishbone register port.
module fsp_serial_port #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // baud sources
    input  wire logic              timer1_ovf,
    input  wire logic              timer2_ovf,
    // serial pins
    input  wire logic              rxd_in,
    output logic                   rxd_out,
    output logic                   rxd_oe,
    output logic                   txd
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and bus decode

    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
        reg_hit = (adr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx}) && (adr[1:0] == 2'b00);
    endfunction

    logic [7:0]    power_control;
    logic [1:0]    rate_select;
    logic [7:0]    rx_buf;
    fsp_pkg::fsp_mode_t mode;
    logic          mp_enable;
    logic          rx_enable;
    logic          tx_ninth_bit;
    logic          rx_ninth_bit;
    logic          tx_done_flag;
    logic          rx_done_flag;

    logic          bus_req;
    logic          bus_wr;
    logic          wr_ctrl;
    logic          wr_data;
    logic [7:0]    rd_val;
    logic          baud_double_select;

    logic          ti_set;
    logic          ri_set;
    logic          rb8_load;
    logic          rb8_val;
    logic [7:0]    rx_load_val;

    assign bus_req = wb_cyc_i && wb_stb_i;
    // writes take effect at the edge where the master sees ack
    assign bus_wr  = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign wr_ctrl = bus_wr && reg_hit(wb_adr_i, fsp_pkg::IDX_SERIAL_CONTROL);
    assign wr_data = bus_wr && reg_hit(wb_adr_i, fsp_pkg::IDX_SERIAL_DATA);
    assign baud_double_select = power_control[fsp_pkg::BIT_BAUD_DOUBLE];

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req && !wb_ack_o;
    end

    // RULE2 receive buffer on read
    always_comb
    begin
        rd_val = 8'h00;
        if (reg_hit(wb_adr_i, fsp_pkg::IDX_POWER_CONTROL))
            rd_val = power_control;
        else if (reg_hit(wb_adr_i, fsp_pkg::IDX_SERIAL_CONTROL))
            rd_val = {mode, mp_enable, rx_enable, tx_ninth_bit, rx_ninth_bit,
                      tx_done_flag, rx_done_flag};
        else if (reg_hit(wb_adr_i, fsp_pkg::IDX_SERIAL_DATA))
            rd_val = rx_buf;
        else if (reg_hit(wb_adr_i, fsp_pkg::IDX_RATE_SELECT))
            rd_val = {6'h00, rate_select};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_ack_o)
            wb_dat_o <= {24'h00_0000, rd_val};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            power_control <= fsp_pkg::RST_POWER_CONTROL;
            rate_select   <= fsp_pkg::RST_RATE_SELECT;
        end
        else if (bus_wr)
        begin
            if (reg_hit(wb_adr_i, fsp_pkg::IDX_POWER_CONTROL))
                power_control <= wb_dat_i[7:0];
            if (reg_hit(wb_adr_i, fsp_pkg::IDX_RATE_SELECT))
                rate_select <= wb_dat_i[1:0];
        end
    end

    // RULE4 mode and control fields
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mode         <= fsp_pkg::fsp_mode_t'(fsp_pkg::RST_SERIAL_CONTROL[7:6]);
            mp_enable    <= fsp_pkg::RST_SERIAL_CONTROL[fsp_pkg::BIT_MP_ENABLE];
            rx_enable    <= fsp_pkg::RST_SERIAL_CONTROL[fsp_pkg::BIT_RX_ENABLE];
            tx_ninth_bit <= fsp_pkg::RST_SERIAL_CONTROL[fsp_pkg::BIT_TX_NINTH];
        end
        else if (wr_ctrl)
        begin
            mode         <= fsp_pkg::fsp_mode_t'(wb_dat_i[7:6]);
            mp_enable    <= wb_dat_i[fsp_pkg::BIT_MP_ENABLE];
            rx_enable    <= wb_dat_i[fsp_pkg::BIT_RX_ENABLE];
            tx_ninth_bit <= wb_dat_i[fsp_pkg::BIT_TX_NINTH];
        end
    end

    // RULE8 transmit done, set wins over the software clear
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            tx_done_flag <= 1'b0;
        else if (ti_set)
            tx_done_flag <= 1'b1;
        else if (wr_ctrl)
            tx_done_flag <= wb_dat_i[fsp_pkg::BIT_TX_DONE];
    end

    // RULE9 receive done, set wins over the software clear
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rx_done_flag <= 1'b0;
        else if (ri_set)
            rx_done_flag <= 1'b1;
        else if (wr_ctrl)
            rx_done_flag <= wb_dat_i[fsp_pkg::BIT_RX_DONE];
    end

    // RULE7 received ninth bit or stop bit
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rx_ninth_bit <= 1'b0;
        else if (rb8_load)
            rx_ninth_bit <= rb8_val;
        else if (wr_ctrl)
            rx_ninth_bit <= wb_dat_i[fsp_pkg::BIT_RX_NINTH];
    end

    // RULE3 holding buffer separate from the shift register
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rx_buf <= fsp_pkg::RST_SERIAL_DATA;
        else if (ri_set)
            rx_buf <= rx_load_val;
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud rate ticks at sixteen times the bit rate

    logic [1:0] pre_cnt;
    logic       t1_half;
    logic       t2_half;
    logic       fixed_tick;
    logic       t1_tick;
    logic       t2_tick;
    logic       tx_tick;
    logic       rx_tick;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pre_cnt <= 2'h0;
            t1_half <= 1'b0;
            t2_half <= 1'b0;
        end
        else
        begin
            pre_cnt <= pre_cnt + 2'h1;
            if (timer1_ovf)
                t1_half <= !t1_half;
            if (timer2_ovf)
                t2_half <= !t2_half;
        end
    end

    // RULE15 oscillator over 32 or 64 through sixteen ticks
    assign fixed_tick = baud_double_select ? pre_cnt[0] : (pre_cnt == 2'h3);
    // RULE20 timer 1 over 16 or 32
    assign t1_tick = baud_double_select ? timer1_ovf : (timer1_ovf && t1_half);
    // RULE21 timer 2 over 32 regardless of doubling
    assign t2_tick = timer2_ovf && t2_half;

    // RULE22 per-direction source select
    // RULE16 variable 9-bit mode shares the timer path
    assign tx_tick = (mode == fsp_pkg::FSP_MODE_FIXED9) ? fixed_tick :
                     (rate_select[fsp_pkg::BIT_TX_SRC] ? t2_tick : t1_tick);
    assign rx_tick = (mode == fsp_pkg::FSP_MODE_FIXED9) ? fixed_tick :
                     (rate_select[fsp_pkg::BIT_RX_SRC] ? t2_tick : t1_tick);

    ////////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser

    logic rxd_meta;
    logic rxd_sync;
    logic rxd_prev;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            rxd_prev <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd_in;
            rxd_sync <= rxd_meta;
            rxd_prev <= rxd_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift register mode engine

    logic       m0_busy;
    logic       m0_rx;
    logic [3:0] m0_cnt;
    logic [2:0] m0_bit;
    logic [7:0] m0_sh;
    logic       m0_arm;
    logic       m0_arm_d;
    logic       m0_done;

    assign m0_arm  = (mode == fsp_pkg::FSP_MODE_SHIFT) && rx_enable && !rx_done_flag;
    assign m0_done = m0_busy && (m0_cnt == fsp_pkg::MODE0_LAST) && (m0_bit == 3'h7);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            m0_arm_d <= 1'b0;
        else
            m0_arm_d <= m0_arm;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            m0_busy <= 1'b0;
            m0_rx   <= 1'b0;
            m0_cnt  <= 4'h0;
            m0_bit  <= 3'h0;
            m0_sh   <= 8'h00;
        end
        // RULE1 a write restarts the engine as transmitter
        else if (wr_data && (mode == fsp_pkg::FSP_MODE_SHIFT))
        begin
            m0_busy <= 1'b1;
            m0_rx   <= 1'b0;
            m0_cnt  <= 4'h0;
            m0_bit  <= 3'h0;
            m0_sh   <= wb_dat_i[7:0];
        end
        // RULE11 reception starts as the armed condition appears
        else if (m0_arm && !m0_arm_d && !m0_busy)
        begin
            m0_busy <= 1'b1;
            m0_rx   <= 1'b1;
            m0_cnt  <= 4'h0;
            m0_bit  <= 3'h0;
        end
        else if (m0_busy)
        begin
            // RULE10 one bit per twelve cycles, lsb first
            if (m0_rx && (m0_cnt == fsp_pkg::MODE0_RISE))
                m0_sh <= {rxd_sync, m0_sh[7:1]};
            if (m0_cnt == fsp_pkg::MODE0_LAST)
            begin
                m0_cnt <= 4'h0;
                m0_bit <= m0_bit + 3'h1;
                if (!m0_rx)
                    m0_sh <= {1'b0, m0_sh[7:1]};
                if (m0_bit == 3'h7)
                    m0_busy <= 1'b0;
            end
            else
                m0_cnt <= m0_cnt + 4'h1;
            // RULE5 clearing enable aborts a shift reception
            if (m0_rx && !rx_enable)
                m0_busy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous transmitter

    logic        tx_busy;
    logic [10:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_sub;
    logic        tx_end;

    assign tx_end = tx_busy && tx_tick && (tx_sub == fsp_pkg::SUB_LAST) && (tx_bits == 4'h1);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            tx_busy <= 1'b0;
            tx_sh   <= 11'h7ff;
            tx_bits <= 4'h0;
            tx_sub  <= 4'h0;
        end
        else if (wr_data && (mode != fsp_pkg::FSP_MODE_SHIFT))
        begin
            tx_busy <= 1'b1;
            tx_sub  <= 4'h0;
            // RULE13 start, data lsb first, stop
            if (mode == fsp_pkg::FSP_MODE_ASYNC8)
            begin
                tx_sh   <= {2'b11, wb_dat_i[7:0], 1'b0};
                tx_bits <= fsp_pkg::FRAME_BITS8;
            end
            else
            begin
                // RULE6 ninth bit from the software field
                tx_sh   <= {1'b1, tx_ninth_bit, wb_dat_i[7:0], 1'b0};
                tx_bits <= fsp_pkg::FRAME_BITS9;
            end
        end
        else if (tx_busy && tx_tick)
        begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == fsp_pkg::SUB_LAST)
            begin
                tx_sh   <= {1'b1, tx_sh[10:1]};
                tx_bits <= tx_bits - 4'h1;
                if (tx_bits == 4'h1)
                    tx_busy <= 1'b0;
            end
        end
    end

    assign ti_set = tx_end || (m0_done && !m0_rx);

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous receiver

    fsp_pkg::fsp_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic       rx_nine;
    logic       rx_end;
    logic       rx_accept;
    logic [7:0] rx_data;

    assign rx_nine = (mode != fsp_pkg::FSP_MODE_ASYNC8);
    assign rx_end  = (rx_state == fsp_pkg::FSP_RX_STOP) && rx_tick &&
                     (rx_sub == fsp_pkg::SUB_LAST);
    assign rx_data = rx_nine ? rx_sh[7:0] : rx_sh[8:1];

    // RULE17 ninth bit zero blocked while multiprocessor enable set
    // RULE19 clearing the enable lets data frames through
    assign rx_accept = !rx_done_flag &&
                       (!mp_enable || (rx_nine ? rx_sh[8] : rxd_sync));

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rx_state <= fsp_pkg::FSP_RX_IDLE;
            rx_sub   <= 4'h0;
            rx_cnt   <= 4'h0;
            rx_sh    <= 9'h000;
        end
        // RULE5 receiver held idle without enable
        else if (!rx_enable || (mode == fsp_pkg::FSP_MODE_SHIFT))
            rx_state <= fsp_pkg::FSP_RX_IDLE;
        else
        begin
            case (rx_state)
                fsp_pkg::FSP_RX_IDLE:
                begin
                    // RULE12 falling edge of the start bit
                    if (rxd_prev && !rxd_sync)
                    begin
                        rx_state <= fsp_pkg::FSP_RX_START;
                        rx_sub   <= 4'h0;
                    end
                end
                fsp_pkg::FSP_RX_START:
                begin
                    if (rx_tick)
                    begin
                        rx_sub <= rx_sub + 4'h1;
                        // RULE23 start confirmed at its centre
                        // RULE14 start bit aligns the bit timing
                        if (rx_sub == fsp_pkg::SUB_CENTRE)
                        begin
                            rx_sub   <= 4'h0;
                            rx_cnt   <= 4'h0;
                            rx_state <= rxd_sync ? fsp_pkg::FSP_RX_IDLE
                                                 : fsp_pkg::FSP_RX_DATA;
                        end
                    end
                end
                fsp_pkg::FSP_RX_DATA:
                begin
                    if (rx_tick)
                    begin
                        rx_sub <= rx_sub + 4'h1;
                        // RULE23 sample near each bit centre
                        if (rx_sub == fsp_pkg::SUB_LAST)
                        begin
                            rx_sh  <= {rxd_sync, rx_sh[8:1]};
                            rx_cnt <= rx_cnt + 4'h1;
                            if (rx_cnt == (rx_nine ? 4'h8 : 4'h7))
                                rx_state <= fsp_pkg::FSP_RX_STOP;
                        end
                    end
                end
                fsp_pkg::FSP_RX_STOP:
                begin
                    if (rx_tick)
                        rx_sub <= rx_sub + 4'h1;
                    if (rx_end)
                        rx_state <= fsp_pkg::FSP_RX_IDLE;
                end
                default:
                    rx_state <= fsp_pkg::FSP_RX_IDLE;
            endcase
        end
    end

    // RULE14 data to buffer, stop to ninth field in 8-bit mode
    assign ri_set      = (rx_end && rx_accept) || (m0_done && m0_rx);
    assign rx_load_val = (m0_done && m0_rx) ? m0_sh : rx_data;
    assign rb8_load    = rx_end && rx_accept;
    assign rb8_val     = rx_nine ? rx_sh[8] : rxd_sync;

    ////////////////////////////////////////////////////////////////////////////
    // pins

    // RULE10 transmit pin carries the shift clock in shift mode
    assign txd     = (mode == fsp_pkg::FSP_MODE_SHIFT) ?
                     (!m0_busy || (m0_cnt >= fsp_pkg::MODE0_RISE)) :
                     (!tx_busy || tx_sh[0]);
    assign rxd_oe  = m0_busy && !m0_rx && (mode == fsp_pkg::FSP_MODE_SHIFT);
    assign rxd_out = m0_sh[0];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_tx_load_start: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_data && (mode != fsp_pkg::FSP_MODE_SHIFT) |=> tx_busy && !txd) // RULE1
        else $error("write did not start an async frame");
    a_ti_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        tx_done_flag && !wr_ctrl |=> tx_done_flag) // RULE8
        else $error("transmit done cleared by hardware");
    a_ri_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        rx_done_flag && !wr_ctrl |=> rx_done_flag) // RULE9
        else $error("receive done cleared by hardware");
    a_rx_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
        !rx_enable |=> rx_state == fsp_pkg::FSP_RX_IDLE) // RULE5
        else $error("receiver active while disabled");
    a_shift_clock: assert property (@(posedge sys_clk) disable iff (!resetn)
        m0_busy && (mode == fsp_pkg::FSP_MODE_SHIFT) |->
        (txd == (m0_cnt >= fsp_pkg::MODE0_RISE))) // RULE10
        else $error("shift clock phase wrong");
    a_mp_filter: assert property (@(posedge sys_clk) disable iff (!resetn)
        rx_end && rx_nine && mp_enable && !rx_sh[8] && !rx_done_flag && !wr_ctrl
        && !m0_done |=> !rx_done_flag) // RULE17
        else $error("ninth bit zero frame raised receive done");
    a_tx_ninth: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_data && mode[1] |=> tx_sh[9] == $past(tx_ninth_bit)) // RULE6
        else $error("ninth transmit bit not from software field");
    a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) // Wishbone register port handshake
        else $error("bus ack not a single cycle answer");

    c_async_tx: cover property (@(posedge sys_clk) disable iff (!resetn) tx_end);
    c_async_rx: cover property (@(posedge sys_clk) disable iff (!resetn) rx_end && rx_accept);
    c_shift_rx: cover property (@(posedge sys_clk) disable iff (!resetn) m0_done && m0_rx);
    c_mp_block: cover property (@(posedge sys_clk) disable iff (!resetn)
        rx_end && mp_enable && !rx_accept);

endmodule

//--- verification/fsp_link_model.sv
// remote serial sender that drives the port's receive pin
// assumes send_frame is called just after a rising edge of sys_clk
module fsp_link_model (
    // clock
    input  wire logic sys_clk,
    // line to the port
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'b1;
    task automatic send_frame(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++)
        begin
            line <= f[i];
            repeat (per) @(posedge sys_clk);
        end
        line <= 1'b1;
    endtask
endmodule

//--- verification/four_mode_serial_port_tb_top.sv
// self-checking bench of the serial port in all four modes
// assumes 125 MHz sys_clk and a register bus answering within 20 cycles
module four_mode_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SC = fsp_pkg::IDX_SERIAL_CONTROL;
    localparam logic [7:0] SD = fsp_pkg::IDX_SERIAL_DATA;
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [11:0] adr     = 12'h000;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] dat     = 32'h0;
    logic [31:0] dout;
    logic [31:0] rdat;
    logic        ack;
    logic        line;
    logic        txd;
    logic        rxd_out;
    logic        rxd_oe;
    logic [1:0]  tcnt  = 2'h0;
    logic        t1ovf = 1'b0;
    logic        t2ovf = 1'b0;
    int          fail_count = 0;
    int          checks     = 0;
    fsp_serial_port uut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .timer1_ovf(t1ovf), .timer2_ovf(t2ovf), .rxd_in(line),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
    fsp_link_model link (.sys_clk(sys_clk), .line(line));
    initial forever #4 sys_clk = ~sys_clk;
    // timer overflow pulses: timer 1 every 4 cycles, timer 2 every 2 cycles
    always @(posedge sys_clk)
    begin
        tcnt  <= tcnt + 2'h1;
        t1ovf <= (tcnt == 2'h3);
        t2ovf <= tcnt[0];
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {2'h0, idx, 2'h0};
        sel <= 4'hf;
        dat <= {24'h0, d};
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, SC, 8'h00);
            n++;
        end while (rdat[b] !== 1'b1 && n < 400);
        chk("done flag", 32'h1, {31'h0, rdat[b]});
        if (rdat[b] !== 1'b1)
            report_and_stop();
    endtask
    task automatic t_reset();
        logic [7:0] idx [4];
        idx = '{fsp_pkg::IDX_POWER_CONTROL, SC, SD, 8'h10};
        foreach (idx[i])
        begin
            bus(1'b0, idx[i], 8'h00);
            chk("reset value", 32'h0, rdat);
        end
    endtask
    task automatic t_tx();
        logic [10:0] f;
        f = {2'b11, 8'ha5, 1'b0};
        bus(1'b1, SC, 8'h88);
        bus(1'b1, SD, 8'ha5);
        repeat (31) @(posedge sys_clk);
        for (int i = 0; i < 11; i++)
        begin
            chk("txd bit", {31'h0, f[i]}, {31'h0, txd});
            repeat (64) @(posedge sys_clk);
        end
        wait_flag(1);
        repeat (50) @(posedge sys_clk);
        bus(1'b0, SC, 8'h00);
        chk("tx done kept", 32'h1, {31'h0, rdat[1]});
    endtask
    task automatic t_rx();
        bus(1'b1, SC, 8'h90);
        link.send_frame({2'b11, 8'h3c, 1'b0}, 11, 64);
        wait_flag(0);
        chk("rx ninth", 32'h1, {31'h0, rdat[2]});
        bus(1'b0, SD, 8'h00);
        chk("rx data", 32'h3c, rdat);
    endtask
    task automatic t_mp();
        bus(1'b1, SC, 8'hb0);
        link.send_frame({2'b10, 8'h11, 1'b0}, 11, 64);
        repeat (20) @(posedge sys_clk);
        bus(1'b0, SC, 8'h00);
        chk("mp data frame", 32'h0, {31'h0, rdat[0]});
        link.send_frame({2'b11, 8'h42, 1'b0}, 11, 64);
        wait_flag(0);
        bus(1'b0, SD, 8'h00);
        chk("mp address", 32'h42, rdat);
        bus(1'b1, SC, 8'h90);
        link.send_frame({2'b10, 8'h77, 1'b0}, 11, 64);
        wait_flag(0);
        bus(1'b0, SD, 8'h00);
        chk("mp cleared data", 32'h77, rdat);
    endtask
    task automatic t_shift();
        logic [7:0] d;
        d = 8'hc3;
        bus(1'b1, SC, 8'h00);
        bus(1'b1, SD, d);
        for (int i = 0; i < 8; i++)
        begin
            repeat (3) @(posedge sys_clk);
            chk("shift low", {29'h0, 2'b01, d[i]}, {29'h0, txd, rxd_oe, rxd_out});
            repeat (6) @(posedge sys_clk);
            chk("shift high", 32'h1, {31'h0, txd});
            repeat (3) @(posedge sys_clk);
        end
        wait_flag(1);
        chk("shift oe", 32'h0, {31'h0, rxd_oe});
        bus(1'b1, SC, 8'h10);
        wait_flag(0);
        bus(1'b0, SD, 8'h00);
        chk("shift rx", 32'hff, rdat);
    endtask
    task automatic t_var();
        bus(1'b1, fsp_pkg::IDX_POWER_CONTROL, 8'h80);
        bus(1'b1, SC, 8'h50);
        link.send_frame({2'b11, 8'h5a, 1'b0}, 10, 64);
        wait_flag(0);
        chk("stop to ninth", 32'h1, {31'h0, rdat[2]});
        bus(1'b0, SD, 8'h00);
        chk("async8 data", 32'h5a, rdat);
        bus(1'b1, fsp_pkg::IDX_POWER_CONTROL, 8'h00);
        bus(1'b1, fsp_pkg::IDX_RATE_SELECT, 8'h02);
        bus(1'b1, SC, 8'hd0);
        link.send_frame({2'b10, 8'h96, 1'b0}, 11, 64);
        wait_flag(0);
        chk("var9 ninth", 32'h0, {31'h0, rdat[2]});
        bus(1'b0, SD, 8'h00);
        chk("var9 data", 32'h96, rdat);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_tx();
        t_rx();
        t_mp();
        t_shift();
        t_var();
        report_and_stop();
    end
endmodule
